/* hdl/mic_irq_ctrl.sv */
// Function
// - eight engines, each enabled alone; a true condition sets status and drives mapped pin
// - each pin is the OR of all engines mapped onto it
// - status changes from conditions only when new acceleration data is stored
// - disabling an engine clears its status at once
// - a 4-bit code picks non-latched, latched or temporary mode for all engines but new data
// - temporary codes select hold times from 250 us to 8 s
// - no mode mechanism but the latched reset bit clears an interrupt while its condition still holds
// - non-latched status and pin clear once the condition stops holding
// - orientation and flat reset themselves in non-latched mode once a fixed time has passed and their condition no longer holds
// - latched status stays until software writes the interrupt reset bit
// - a cleared latched interrupt with condition still true returns at next update
// - temporary mode clears an interrupt once its hold time has passed and its condition no longer holds
// - source bits choose filtered (0) or unfiltered (1) data for six engines
// - orientation and flat always use filtered data
// - map registers hold one bit per engine for pin one and pin two
// - pin level bit sets active polarity, drive bit selects open-drain or push-pull
// - new data engine is always non-latched
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module mic_irq_ctrl #(
    parameter int TICK_CYCLES = mic_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // wishbone classic slave
    input  wire logic       wb_cyc,
    input  wire logic       wb_stb,
    input  wire logic       wb_we,
    input  wire logic [7:0] wb_adr,
    input  wire logic [3:0] wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic            wb_ack,
    // engine conditions and data store strobe
    input  wire logic       data_stored,
    input  wire logic [7:0] cond_filt,
    input  wire logic [7:0] cond_unfilt,
    // interrupt pins
    output logic            irq_pin_one,
    output logic            irq_pin_one_oe,
    output logic            irq_pin_two,
    output logic            irq_pin_two_oe
);
    import mic_pkg::*;

    localparam int DIV_W = $clog2(TICK_CYCLES + 1);

    logic [7:0]  enable_q, enable_d;
    logic [7:0]  map_one_q, map_one_d;
    logic [7:0]  map_shared_q, map_shared_d;
    logic [7:0]  map_two_q, map_two_d;
    logic [7:0]  src_q, src_d;
    logic [7:0]  pin_cfg_q, pin_cfg_d;
    logic [3:0]  mode_code_q, mode_code_d;
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        clear_strobe;
    logic [DIV_W-1:0] div_q, div_d;
    logic        tick;
    logic [7:0]  status;
    logic [7:0]  cond_sel;
    logic [7:0]  map_one_eff, map_two_eff;
    logic        active_one, active_two;
    mic_mode_t   mode;
    logic [TIMER_W-1:0] hold_ticks;

    // bus slave: one wait state, every address answers
    logic       req;
    logic [5:0] idx;
    logic       wr_hit;
    assign req    = wb_cyc && wb_stb && !ack_q;
    assign idx    = wb_adr[7:2];
    assign wr_hit = req && wb_we && wb_sel[0];

    always_comb
    begin
        enable_d     = enable_q;
        map_one_d    = map_one_q;
        map_shared_d = map_shared_q;
        map_two_d    = map_two_q;
        src_d        = src_q;
        pin_cfg_d    = pin_cfg_q;
        mode_code_d  = mode_code_q;
        clear_strobe = 1'b0;
        ack_d        = req;
        rdata_d      = rdata_q;
        if (wr_hit)
        begin
            if (idx == IDX_ENABLE)
                enable_d = wb_dat_w[7:0];
            else if (idx == IDX_MAP_ONE)
                map_one_d = wb_dat_w[7:0];
            else if (idx == IDX_MAP_SHARED)
                map_shared_d = wb_dat_w[7:0];
            else if (idx == IDX_MAP_TWO)
                map_two_d = wb_dat_w[7:0];
            else if (idx == IDX_SRC)
                src_d = wb_dat_w[7:0];
            else if (idx == IDX_PIN_CFG)
                pin_cfg_d = wb_dat_w[7:0];
            else if (idx == IDX_LATCH)
            begin
                mode_code_d  = wb_dat_w[LATCH_MODE_LSB +: 4];
                clear_strobe = wb_dat_w[LATCH_RESET_BIT];
            end
        end
        if (req && !wb_we)
        begin
            rdata_d = 32'h0000_0000;
            if (idx == IDX_STATUS)
                rdata_d[7:0] = status;
            else if (idx == IDX_ENABLE)
                rdata_d[7:0] = enable_q;
            else if (idx == IDX_MAP_ONE)
                rdata_d[7:0] = {map_one_q[7:1], 1'b0};
            else if (idx == IDX_MAP_SHARED)
                rdata_d[7:0] = map_shared_q;
            else if (idx == IDX_MAP_TWO)
                rdata_d[7:0] = {map_two_q[7:1], 1'b0};
            else if (idx == IDX_SRC)
                rdata_d[7:0] = {2'b00, src_q[5:0]};
            else if (idx == IDX_PIN_CFG)
                rdata_d[7:0] = {4'h0, pin_cfg_q[3:0]};
            else if (idx == IDX_LATCH)
                rdata_d[7:0] = {4'h0, mode_code_q}; // reset bit reads zero
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            enable_q     <= RESET_VAL;
            map_one_q    <= RESET_VAL;
            map_shared_q <= RESET_VAL;
            map_two_q    <= RESET_VAL;
            src_q        <= RESET_VAL;
            pin_cfg_q    <= RESET_VAL;
            mode_code_q  <= RESET_VAL[3:0];
            ack_q        <= 1'b0;
            rdata_q      <= 32'h0000_0000;
        end
        else
        begin
            enable_q     <= enable_d;
            map_one_q    <= map_one_d;
            map_shared_q <= map_shared_d;
            map_two_q    <= map_two_d;
            src_q        <= src_d;
            pin_cfg_q    <= pin_cfg_d;
            mode_code_q  <= mode_code_d;
            ack_q        <= ack_d;
            rdata_q      <= rdata_d;
        end
    end

    assign wb_ack   = ack_q;
    assign wb_dat_r = rdata_q;

    // tick divider; shared by all hold counters to save area
    always_comb
    begin
        tick  = (div_q == DIV_W'(TICK_CYCLES - 1));
        div_d = tick ? '0 : div_q + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            div_q <= '0;
        else
            div_q <= div_d;
    end

    // mode decode
    always_comb
    begin
        if (mode_code_q == CODE_NONLATCH_A || mode_code_q == CODE_NONLATCH_B)
            mode = MIC_NONLATCHED;
        else if (mode_code_q == CODE_LATCH_A || mode_code_q == CODE_LATCH_B)
            mode = MIC_LATCHED;
        else
            mode = MIC_TEMPORARY;
        hold_ticks = mic_hold_ticks(mode_code_q);
    end

    // source selection
    always_comb
    begin
        cond_sel                 = cond_filt;
        cond_sel[ENG_DATA]       = src_q[SRC_DATA] ? cond_unfilt[ENG_DATA] : cond_filt[ENG_DATA];
        cond_sel[ENG_LOW]        = src_q[SRC_LOW] ? cond_unfilt[ENG_LOW] : cond_filt[ENG_LOW];
        cond_sel[ENG_HIGH]       = src_q[SRC_HIGH] ? cond_unfilt[ENG_HIGH] : cond_filt[ENG_HIGH];
        cond_sel[ENG_SLOPE]      = src_q[SRC_SLOPE] ? cond_unfilt[ENG_SLOPE]
                                                    : cond_filt[ENG_SLOPE];
        cond_sel[ENG_SLO_NO_MOT] = src_q[SRC_SLO_NO_MOT] ? cond_unfilt[ENG_SLO_NO_MOT]
                                                         : cond_filt[ENG_SLO_NO_MOT];
        cond_sel[ENG_TAP]        = src_q[SRC_TAP] ? cond_unfilt[ENG_TAP] : cond_filt[ENG_TAP];
        // orientation and flat keep the filtered value from the default above
    end

    // per-engine status and hold counter
    for (genvar g = 0; g < NUM_ENG; g++)
    begin : g_eng
        logic st_q, st_d;
        logic cnd_q, cnd_d;
        logic [TIMER_W-1:0] tmr_q, tmr_d;
        logic fixed_eng;
        logic expired;
        assign fixed_eng = (g == ENG_ORIENT) || (g == ENG_FLAT);

        always_comb
        begin
            expired = (tmr_q >= hold_ticks);
            st_d    = st_q;
            cnd_d   = cnd_q;
            tmr_d   = tmr_q;
            if (tick && st_q && tmr_q != '1)
                tmr_d = tmr_q + 1'b1;
            if (!enable_q[g])
            begin
                st_d  = 1'b0;
                cnd_d = 1'b0;
                tmr_d = '0;
            end
            else if (data_stored)
            begin
                cnd_d = cond_sel[g];
                if (cond_sel[g])
                begin
                    st_d = 1'b1;
                    if (!st_q)
                        tmr_d = '0;
                end
                else if (g == ENG_DATA)
                    st_d = 1'b0;
                else if (mode == MIC_NONLATCHED && !fixed_eng)
                    st_d = 1'b0;
            end
            if (enable_q[g] && g != ENG_DATA)
            begin
                // a new assertion in the strobe cycle wins over the clear
                if (mode == MIC_LATCHED && clear_strobe && !(data_stored && cond_sel[g]))
                    st_d = 1'b0;
                else if (mode == MIC_TEMPORARY && expired && !cnd_d)
                    st_d = 1'b0;
                else if (mode == MIC_NONLATCHED && fixed_eng && !cnd_d
                         && tmr_q >= FIXED_HOLD_TICKS)
                    st_d = 1'b0;
            end
        end

        always_ff @(posedge clk_sys)
        begin
            if (reset)
            begin
                st_q  <= 1'b0;
                cnd_q <= 1'b0;
                tmr_q <= '0;
            end
            else
            begin
                st_q  <= st_d;
                cnd_q <= cnd_d;
                tmr_q <= tmr_d;
            end
        end

        assign status[g] = st_q;
    end

    // pin mapping and drivers
    always_comb
    begin
        map_one_eff           = map_one_q;
        map_one_eff[ENG_DATA] = map_shared_q[SHARED_DATA_ONE];
        map_two_eff           = map_two_q;
        map_two_eff[ENG_DATA] = map_shared_q[SHARED_DATA_TWO];
        active_one            = |(status & map_one_eff);
        active_two            = |(status & map_two_eff);
    end

    always_comb
    begin
        irq_pin_one    = pin_cfg_q[CFG_ONE_LVL] ? active_one : !active_one;
        irq_pin_two    = pin_cfg_q[CFG_TWO_LVL] ? active_two : !active_two;
        // open-drain only pulls the pin low, the pull resistor gives the high level
        irq_pin_one_oe = !pin_cfg_q[CFG_ONE_OD] || !irq_pin_one;
        irq_pin_two_oe = !pin_cfg_q[CFG_TWO_OD] || !irq_pin_two;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    status_disable_a: assert property ($fell(enable_q[ENG_SLOPE]) |=> !status[ENG_SLOPE])
        else $error("status stayed set after disable");
    pin_one_or_a: assert property (irq_pin_one == (pin_cfg_q[CFG_ONE_LVL]
                                   ~^ (|(status & map_one_eff))))
        else $error("pin one not the OR of mapped status");
    set_at_update_a: assert property ((status & ~$past(status)) != 8'h00 |-> $past(data_stored))
        else $error("status set without data update");
    latched_hold_a: assert property (mode == MIC_LATCHED && status[ENG_SLOPE]
                                     && enable_q[ENG_SLOPE] && !clear_strobe
                                     |=> status[ENG_SLOPE])
        else $error("latched status dropped without reset strobe");
    latched_clear_a: assert property (mode == MIC_LATCHED && clear_strobe && enable_q[ENG_SLOPE]
                                      && !(data_stored && cond_sel[ENG_SLOPE])
                                      |=> !status[ENG_SLOPE])
        else $error("reset strobe did not clear latched status");
    reset_reads_zero_a: assert property (ack_q && $past(req && !wb_we && idx == IDX_LATCH)
                                         |-> wb_dat_r[LATCH_RESET_BIT] == 1'b0)
        else $error("interrupt reset bit read back as one");
    temp_cond_hold_a: assert property (mode == MIC_TEMPORARY && enable_q[ENG_SLOPE]
                                       && g_eng[ENG_SLOPE].cnd_q && status[ENG_SLOPE]
                                       && !data_stored |=> status[ENG_SLOPE])
        else $error("temporary interrupt cleared while condition holds");
    data_follow_a: assert property (data_stored && enable_q[ENG_DATA]
                                    |=> status[ENG_DATA] == $past(cond_sel[ENG_DATA]))
        else $error("new data status not non-latched");
    nonlatch_clear_a: assert property (mode == MIC_NONLATCHED && data_stored
                                       && !cond_sel[ENG_SLOPE] |=> !status[ENG_SLOPE])
        else $error("non-latched status kept after condition fell");
    orient_filt_a: assert property (cond_sel[ENG_ORIENT] == cond_filt[ENG_ORIENT])
        else $error("orientation engine used unfiltered data");
    ack_pulse_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
        else $error("ack not a single cycle answer");

    latched_cov_c: cover property (mode == MIC_LATCHED && clear_strobe && status != 8'h00);
    temp_expire_c: cover property (mode == MIC_TEMPORARY && $fell(status[ENG_SLOPE]));
    pin_two_c: cover property ($rose(active_two));

endmodule : mic_irq_ctrl

/* hdl/mic_pkg.sv */
package mic_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [5:0] IDX_STATUS     = 6'h09;
    localparam logic [5:0] IDX_ENABLE     = 6'h16;
    localparam logic [5:0] IDX_MAP_ONE    = 6'h19;
    localparam logic [5:0] IDX_MAP_SHARED = 6'h1A;
    localparam logic [5:0] IDX_MAP_TWO    = 6'h1B;
    localparam logic [5:0] IDX_SRC        = 6'h1E;
    localparam logic [5:0] IDX_PIN_CFG    = 6'h20;
    localparam logic [5:0] IDX_LATCH      = 6'h21;

    // engine positions in status, enable and map registers
    localparam int ENG_DATA       = 0;
    localparam int ENG_LOW        = 1;
    localparam int ENG_HIGH       = 2;
    localparam int ENG_SLOPE      = 3;
    localparam int ENG_SLO_NO_MOT = 4;
    localparam int ENG_TAP        = 5;
    localparam int ENG_ORIENT     = 6;
    localparam int ENG_FLAT       = 7;
    localparam int NUM_ENG        = 8;

    // source select fields
    localparam int SRC_LOW        = 0;
    localparam int SRC_HIGH       = 1;
    localparam int SRC_SLO_NO_MOT = 2;
    localparam int SRC_SLOPE      = 3;
    localparam int SRC_TAP        = 4;
    localparam int SRC_DATA       = 5;

    // shared map register: new data engine onto each pin
    localparam int SHARED_DATA_ONE = 0;
    localparam int SHARED_DATA_TWO = 7;

    // pin configuration fields
    localparam int CFG_ONE_LVL = 0;
    localparam int CFG_ONE_OD  = 1;
    localparam int CFG_TWO_LVL = 2;
    localparam int CFG_TWO_OD  = 3;

    // latch control fields
    localparam int LATCH_MODE_LSB  = 0;
    localparam int LATCH_RESET_BIT = 7;

    localparam logic [7:0] RESET_VAL = 8'h00;

    localparam logic [3:0] CODE_NONLATCH_A = 4'h0;
    localparam logic [3:0] CODE_NONLATCH_B = 4'h8;
    localparam logic [3:0] CODE_LATCH_A    = 4'h7;
    localparam logic [3:0] CODE_LATCH_B    = 4'hF;

    typedef enum logic [1:0] {MIC_NONLATCHED, MIC_LATCHED, MIC_TEMPORARY} mic_mode_t;

    // time base: one tick every 250 us at a 5 ns clock
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TICK_TIME_US  = 250;
    localparam int TICK_CYCLES   = TICK_TIME_US * 1000 * 1000 / CLK_PERIOD_PS;

    localparam int TIMER_W = 16;
    localparam int HOLD_TIME_US [16] = '{0, 250000, 500000, 1000000, 2000000, 4000000,
                                         8000000, 0, 0, 250, 500, 1000, 12500, 25000,
                                         50000, 0};
    // fixed self-reset time of orientation and flat in non-latched mode
    localparam int FIXED_HOLD_US    = 12500;
    localparam logic [TIMER_W-1:0] FIXED_HOLD_TICKS = TIMER_W'(FIXED_HOLD_US / TICK_TIME_US);

    function automatic logic [TIMER_W-1:0] mic_hold_ticks(input logic [3:0] code);
        return TIMER_W'(HOLD_TIME_US[code] / TICK_TIME_US);
    endfunction : mic_hold_ticks

endpackage : mic_pkg

/* sim/mic_host_model.sv */
`timescale 1ns/1ps
module mic_host_model (
    // pins from the device
    input  wire logic pin_one,
    input  wire logic pin_one_oe,
    input  wire logic pin_two,
    input  wire logic pin_two_oe,
    // board resistors: high means a pull-up on that line
    input  wire logic pull_one,
    input  wire logic pull_two,
    // levels the host sees on its inputs
    output logic      line_one,
    output logic      line_two
);
    // a released open-drain pin shows the resistor, never the last driven value
    assign line_one = pin_one_oe ? pin_one : pull_one;
    assign line_two = pin_two_oe ? pin_two : pull_two;
endmodule : mic_host_model

/* sim/motion_interrupt_controller_tb.sv */
`timescale 1ns/1ps
module motion_interrupt_controller_tb;
    import mic_pkg::*;
    localparam int TK = 4;
    localparam logic [5:0] IX [9] = '{IDX_STATUS, IDX_ENABLE, IDX_MAP_ONE, IDX_MAP_SHARED,
                                      IDX_MAP_TWO, IDX_SRC, IDX_PIN_CFG, IDX_LATCH, 6'h3F};
    localparam logic [3:0] MD [4] = '{CODE_NONLATCH_A, CODE_NONLATCH_B, CODE_LATCH_A,
                                      CODE_LATCH_B};
    localparam logic [3:0] TC [7] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'h1};
    // hold times in ticks of 250 us
    localparam int         TT [7] = '{1, 2, 4, 50, 100, 200, 1000};
    logic        clk_sys, reset, wb_cyc, wb_stb, wb_we, wb_ack, data_stored;
    logic [7:0]  wb_adr, cf, cu, rd;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic        p1, p1_oe, p2, p2_oe, l1, l2, pu1, pu2;
    int          n_mismatch = 0;
    int          check_count = 0;

    mic_irq_ctrl #(.TICK_CYCLES(TK)) DUT (
        .clk_sys(clk_sys), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(4'hF), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .data_stored(data_stored), .cond_filt(cf), .cond_unfilt(cu),
        .irq_pin_one(p1), .irq_pin_one_oe(p1_oe), .irq_pin_two(p2), .irq_pin_two_oe(p2_oe));

    mic_host_model HOST (
        .pin_one(p1), .pin_one_oe(p1_oe), .pin_two(p2), .pin_two_oe(p2_oe),
        .pull_one(pu1), .pull_two(pu2), .line_one(l1), .line_two(l2));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask : chk1

    // request held from one edge until the edge that samples ack
    task automatic acc(input logic we, input logic [5:0] ix, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        wb_cyc   <= 1'h1;
        wb_stb   <= 1'h1;
        wb_we    <= we;
        wb_adr   <= {ix, 2'h0};
        wb_dat_w <= {24'h000000, d};
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wb_ack !== 1'h1 && n < 64);
        rd = wb_dat_r[7:0];
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        if (n >= 64)
            n_mismatch++;
    endtask : acc

    task automatic wr(input logic [5:0] ix, input logic [7:0] d);
        acc(1'h1, ix, d);
    endtask : wr

    task automatic rg(input logic [5:0] ix, input logic [7:0] e);
        acc(1'h0, ix, 8'h00);
        chk8($sformatf("register %h", ix), e, rd);
    endtask : rg

    // one new acceleration word; conditions stay as given afterwards
    task automatic upd(input logic [7:0] f, input logic [7:0] u);
        @(posedge clk_sys);
        data_stored <= 1'h1;
        cf          <= f;
        cu          <= u;
        @(posedge clk_sys);
        data_stored <= 1'h0;
    endtask : upd

    task automatic pins(input logic e1, input logic e2);
        #1;
        chk1("line one", e1, l1);
        chk1("line two", e2, l2);
    endtask : pins

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wt

    initial
    begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        wt(50000);
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        {reset, pu1, pu2} = 3'h7;
        {wb_cyc, wb_stb, wb_we, data_stored} = 4'h0;
        {wb_adr, cf, cu} = 24'h000000;
        wb_dat_w = 32'h00000000;
        wt(6);
        reset <= 1'h0;
        foreach (IX[i])
            rg(IX[i], RESET_VAL);
        pins(1'h1, 1'h1);
        wr(IDX_MAP_ONE, 8'hFF);
        rg(IDX_MAP_ONE, 8'hFE);
        wr(IDX_MAP_TWO, 8'hFF);
        rg(IDX_MAP_TWO, 8'hFE);
        wr(6'h3F, 8'hFF);
        rg(6'h3F, 8'h00);
        $display("test registers done");

        wr(IDX_MAP_ONE, 8'h08);
        wr(IDX_MAP_TWO, 8'h00);
        wr(IDX_ENABLE, 8'h08);
        upd(8'h08, 8'h00);
        rg(IDX_STATUS, 8'h08);
        pins(1'h0, 1'h1);
        @(posedge clk_sys);
        cf <= 8'h00;
        wt(3);
        rg(IDX_STATUS, 8'h08);
        upd(8'h00, 8'h00);
        rg(IDX_STATUS, 8'h00);
        pins(1'h1, 1'h1);
        wr(IDX_SRC, 8'h08);
        upd(8'h08, 8'h00);
        rg(IDX_STATUS, 8'h00);
        upd(8'h00, 8'h08);
        rg(IDX_STATUS, 8'h08);
        upd(8'h00, 8'h00);
        wr(IDX_SRC, 8'h3F);
        wr(IDX_ENABLE, 8'h48);
        upd(8'h40, 8'h00);
        rg(IDX_STATUS, 8'h40);
        upd(8'h00, 8'h40);
        rg(IDX_STATUS, 8'h40);
        wt(52 * TK);
        rg(IDX_STATUS, 8'h00);
        upd(8'h00, 8'h40);
        rg(IDX_STATUS, 8'h00);
        wr(IDX_SRC, 8'h00);
        wr(IDX_ENABLE, 8'h08);
        $display("test non-latched done");

        foreach (MD[i])
        begin
            wr(IDX_LATCH, {4'h0, MD[i]});
            upd(8'h08, 8'h00);
            upd(8'h00, 8'h00);
            rg(IDX_STATUS, MD[i][2:0] == 3'h7 ? 8'h08 : 8'h00);
            if (MD[i][2:0] == 3'h7)
            begin
                pins(1'h0, 1'h1);
                wr(IDX_LATCH, {4'h8, MD[i]});
                rg(IDX_STATUS, 8'h00);
                rg(IDX_LATCH, {4'h0, MD[i]});
                upd(8'h08, 8'h00);
                wr(IDX_LATCH, {4'h8, MD[i]});
                upd(8'h08, 8'h00);
                rg(IDX_STATUS, 8'h08);
                wr(IDX_ENABLE, 8'h00);
                rg(IDX_STATUS, 8'h00);
                wr(IDX_ENABLE, 8'h08);
            end
        end
        wr(IDX_ENABLE, 8'h01);
        wr(IDX_MAP_SHARED, 8'h80);
        upd(8'h01, 8'h00);
        rg(IDX_STATUS, 8'h01);
        pins(1'h1, 1'h0);
        upd(8'h00, 8'h00);
        rg(IDX_STATUS, 8'h00);
        wr(IDX_MAP_SHARED, 8'h00);
        wr(IDX_ENABLE, 8'h08);
        $display("test latched done");

        foreach (TC[i])
        begin
            wr(IDX_LATCH, {4'h0, TC[i]});
            upd(8'h08, 8'h00);
            upd(8'h00, 8'h00);
            if (TT[i] >= 4)
                rg(IDX_STATUS, 8'h08);
            wt((TT[i] + 2) * TK);
            rg(IDX_STATUS, 8'h00);
        end
        wr(IDX_LATCH, 8'h0B);
        upd(8'h08, 8'h00);
        wt(8 * TK);
        rg(IDX_STATUS, 8'h08);
        upd(8'h00, 8'h00);
        wt(6 * TK);
        rg(IDX_STATUS, 8'h00);
        $display("test temporary done");

        // open-drain active high needs a pull-up: the asserted level is a release
        wr(IDX_LATCH, 8'h00);
        wr(IDX_MAP_TWO, 8'h08);
        wr(IDX_PIN_CFG, 8'h0D);
        upd(8'h08, 8'h00);
        pins(1'h1, 1'h1);
        chk1("pin two enable", 1'h0, p2_oe);
        upd(8'h00, 8'h00);
        pins(1'h0, 1'h0);
        chk1("pin two enable", 1'h1, p2_oe);
        $display("test pins done");
        print_verdict();
    end
endmodule : motion_interrupt_controller_tb
